// >>> verilog/cpu_regs_pkg.sv
// Package for the CPU dedicated register set: widths, flag positions,
// reset values, register selectors and the operation record.
// Assumes a single clock domain; shared by the register set and its users.
package cpu_regs_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;

	// ----------------------------------------------------------------
	// Condition-code byte bit positions
	// ----------------------------------------------------------------
	localparam int CC_HALF_POS  = 7;
	localparam int CC_IEN_POS   = 6;
	localparam int CC_LVLHI_POS = 5;
	localparam int CC_LVLLO_POS = 4;
	localparam int CC_NEG_POS   = 3;
	localparam int CC_ZERO_POS  = 2;
	localparam int CC_OVF_POS   = 1;
	localparam int CC_CARRY_POS = 0;

	// ----------------------------------------------------------------
	// Bank-register address layout
	// ----------------------------------------------------------------
	localparam logic [7:0] GPR_TOP_BITS  = 8'h01;
	localparam int         BANK_SEL_W    = 5;
	localparam int         GPR_IDX_W     = 3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] INSTR_PTR_RST = 16'h0000;
	localparam logic [15:0] WORD_RST      = 16'h0000;
	localparam logic [7:0]  BANK_SEL_RST  = 8'h00;
	localparam logic [7:0]  CC_RST        = 8'h30;

	// ----------------------------------------------------------------
	// Register selector for write and read ports
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SEL_PTR,
		SEL_ACC,
		SEL_TMP,
		SEL_STACK,
		SEL_INDEX,
		SEL_EXTRA,
		SEL_PROC
	} reg_sel_e;

	// Flags that an operation may update
	typedef struct packed {
		logic half;
		logic neg;
		logic zero;
		logic ovf;
		logic carry;
	} flag_mask_s;

	// ALU result record
	typedef struct packed {
		logic        valid;
		logic        wide;
		logic [15:0] result;
		logic        carry_out;
		logic        half_carry;
		logic        ovf;
		flag_mask_s  touch;
	} alu_op_s;

	// Register write from the sequencer
	typedef struct packed {
		logic        en;
		reg_sel_e    sel;
		logic        low_only;
		logic [15:0] data;
	} reg_wr_s;

endpackage

// >>> verilog/cpu_register_set.sv
// CPU dedicated register set: pointer, accumulators, stack, index, extra
// pointer and processor word, with flag update and interrupt level gating.
// Assumes sequencer, ALU and interrupt controller share CLK_SYS_IN.
//
// How it works
// - The instruction pointer is a 16-bit register holding the next fetch address.
// - The accumulator is 16 bits and takes results; byte operations use its low byte.
// - The temporary accumulator is 16 bits, the second operand; byte operations use its low byte.
// - The stack, index and extra pointers are each 16 bits wide.
// - The processor word has the bank select in its upper byte and the flag byte below.
// - A bank register address is zeros, a one at bit 8, five bank bits, then three opcode bits.
// - The half flag follows the carry or borrow from bit 3 into bit 4.
// - The interrupt enable flag permits interrupts when one and is cleared by reset.
// - A request is accepted only if its level is numerically below the current level.
// - The negative flag copies the result's most significant bit.
// - The zero flag is set exactly when the result is zero.
// - The overflow flag reflects two's-complement overflow of the operation.
// - The carry flag takes carry or borrow from bit 7, or the bit shifted out.
// - Bank registers are 8 bits, eight per bank, up to 32 banks chosen by the bank select.
// - Words go to memory high byte first at the lower address.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ns
module cpu_register_set #(
	parameter int BANK_COUNT = 16
) (
	// Clock and reset
	input  wire logic                     CLK_SYS_IN,
	input  wire logic                     SYS_RST_IN,
	// Register write, ALU result, enable and level controls
	input  wire cpu_regs_pkg::reg_wr_s    REG_WR_IN,
	input  wire cpu_regs_pkg::alu_op_s    ALU_OP_IN,
	input  wire logic                     IEN_SET_IN,
	input  wire logic                     IEN_CLR_IN,
	input  wire logic                     LEVEL_WR_IN,
	input  wire logic [1:0]               LEVEL_IN,
	// Read port
	input  wire cpu_regs_pkg::reg_sel_e   RD_SEL_IN,
	output logic [15:0]                   RD_DATA_OUT,
	// Bank register addressing
	input  wire logic [2:0]               GPR_OPCODE_IN,
	output logic [15:0]                   GPR_ADDR_OUT,
	// Interrupt level gate
	input  wire logic                     IRQ_REQ_IN,
	input  wire logic [1:0]               IRQ_LEVEL_IN,
	output logic                          IRQ_ACCEPT_OUT,
	// Word split for memory store
	input  wire cpu_regs_pkg::reg_sel_e   STORE_SEL_IN,
	output logic [7:0]                    STORE_LO_ADDR_BYTE_OUT,
	output logic [7:0]                    STORE_HI_ADDR_BYTE_OUT,
	// Register views
	output logic [15:0]                   INSTR_POINTER_OUT,
	output logic [15:0]                   PROC_WORD_OUT
);

	// Five bank bits in the address serve at most 32 banks
	if (BANK_COUNT < 1 || BANK_COUNT > 32) begin : bank_count_check
		$error("BANK_COUNT must be 1..32");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] instr_pointer;
		logic [15:0] acc;
		logic [15:0] tmp_acc;
		logic [15:0] stack_top_ptr;
		logic [15:0] index_reg;
		logic [15:0] extra_addr_ptr;
		logic [7:0]  bank_select;
		logic [7:0]  cond_code_byte;
		logic [15:0] rd_data;
		logic [15:0] gpr_addr;
		logic        irq_accept;
		logic [7:0]  store_lo;
		logic [7:0]  store_hi;
	} state_s;

	state_s state_reg;
	state_s state_next;

	logic [15:0] sel_word;
	logic [15:0] store_word;
	logic [7:0]  res_byte;
	logic [7:0]  cc;
	logic [1:0]  cur_level;

	function automatic logic [15:0] pick(input state_s s, input cpu_regs_pkg::reg_sel_e sel);
		logic [15:0] v;
		v = 16'h0000;
		case (sel)
			cpu_regs_pkg::SEL_PTR:   v = s.instr_pointer;
			cpu_regs_pkg::SEL_ACC:   v = s.acc;
			cpu_regs_pkg::SEL_TMP:   v = s.tmp_acc;
			cpu_regs_pkg::SEL_STACK: v = s.stack_top_ptr;
			cpu_regs_pkg::SEL_INDEX: v = s.index_reg;
			cpu_regs_pkg::SEL_EXTRA: v = s.extra_addr_ptr;
			cpu_regs_pkg::SEL_PROC:  v = {s.bank_select, s.cond_code_byte};
			default:                 v = 16'h0000;
		endcase
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		cc         = state_reg.cond_code_byte;
		res_byte   = ALU_OP_IN.result[7:0];

		// Register writes; byte writes keep the upper byte
		if (REG_WR_IN.en) begin
			sel_word = pick(state_reg, REG_WR_IN.sel);
			if (REG_WR_IN.low_only)
				sel_word = {sel_word[15:8], REG_WR_IN.data[7:0]};
			else
				sel_word = REG_WR_IN.data;
			case (REG_WR_IN.sel)
				cpu_regs_pkg::SEL_PTR:   state_next.instr_pointer  = sel_word;
				cpu_regs_pkg::SEL_ACC:   state_next.acc            = sel_word;
				cpu_regs_pkg::SEL_TMP:   state_next.tmp_acc        = sel_word;
				cpu_regs_pkg::SEL_STACK: state_next.stack_top_ptr  = sel_word;
				cpu_regs_pkg::SEL_INDEX: state_next.index_reg      = sel_word;
				cpu_regs_pkg::SEL_EXTRA: state_next.extra_addr_ptr = sel_word;
				cpu_regs_pkg::SEL_PROC: begin
					state_next.bank_select = sel_word[15:8];
					cc                     = sel_word[7:0];
				end
				default: ;
			endcase
		end else begin
			sel_word = 16'h0000;
		end

		// ALU result lands in the accumulator and updates touched flags
		if (ALU_OP_IN.valid) begin
			if (ALU_OP_IN.wide)
				state_next.acc = ALU_OP_IN.result;
			else
				state_next.acc = {state_reg.acc[15:8], res_byte};
			if (ALU_OP_IN.touch.half)
				cc[cpu_regs_pkg::CC_HALF_POS] = ALU_OP_IN.half_carry;
			if (ALU_OP_IN.touch.neg)
				cc[cpu_regs_pkg::CC_NEG_POS] = ALU_OP_IN.wide ?
					ALU_OP_IN.result[15] : res_byte[7];
			if (ALU_OP_IN.touch.zero)
				cc[cpu_regs_pkg::CC_ZERO_POS] = ALU_OP_IN.wide ?
					(ALU_OP_IN.result == 16'h0000) : (res_byte == 8'h00);
			if (ALU_OP_IN.touch.ovf)
				cc[cpu_regs_pkg::CC_OVF_POS] = ALU_OP_IN.ovf;
			if (ALU_OP_IN.touch.carry)
				cc[cpu_regs_pkg::CC_CARRY_POS] = ALU_OP_IN.carry_out;
		end

		// Interrupt enable: set wins over clear
		if (IEN_CLR_IN)
			cc[cpu_regs_pkg::CC_IEN_POS] = 1'b0;
		if (IEN_SET_IN)
			cc[cpu_regs_pkg::CC_IEN_POS] = 1'b1;
		if (LEVEL_WR_IN) begin
			cc[cpu_regs_pkg::CC_LVLHI_POS] = LEVEL_IN[1];
			cc[cpu_regs_pkg::CC_LVLLO_POS] = LEVEL_IN[0];
		end
		state_next.cond_code_byte = cc;

		// Outputs registered from current state
		state_next.rd_data = pick(state_reg, RD_SEL_IN);
		state_next.gpr_addr = {cpu_regs_pkg::GPR_TOP_BITS,
			state_reg.bank_select[cpu_regs_pkg::BANK_SEL_W-1:0], GPR_OPCODE_IN};

		cur_level = {state_reg.cond_code_byte[cpu_regs_pkg::CC_LVLHI_POS],
			state_reg.cond_code_byte[cpu_regs_pkg::CC_LVLLO_POS]};
		state_next.irq_accept = IRQ_REQ_IN
			&& state_reg.cond_code_byte[cpu_regs_pkg::CC_IEN_POS]
			&& (IRQ_LEVEL_IN < cur_level);

		store_word = pick(state_reg, STORE_SEL_IN);
		state_next.store_lo = store_word[15:8];
		state_next.store_hi = store_word[7:0];
	end

	always_ff @(posedge CLK_SYS_IN or posedge SYS_RST_IN) begin
		if (SYS_RST_IN) begin
			state_reg                <= '0;
			state_reg.instr_pointer  <= cpu_regs_pkg::INSTR_PTR_RST;
			state_reg.acc            <= cpu_regs_pkg::WORD_RST;
			state_reg.bank_select    <= cpu_regs_pkg::BANK_SEL_RST;
			state_reg.cond_code_byte <= cpu_regs_pkg::CC_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	assign RD_DATA_OUT            = state_reg.rd_data;
	assign GPR_ADDR_OUT           = state_reg.gpr_addr;
	assign IRQ_ACCEPT_OUT         = state_reg.irq_accept;
	assign STORE_LO_ADDR_BYTE_OUT = state_reg.store_lo;
	assign STORE_HI_ADDR_BYTE_OUT = state_reg.store_hi;
	assign INSTR_POINTER_OUT      = state_reg.instr_pointer;
	assign PROC_WORD_OUT          = {state_reg.bank_select, state_reg.cond_code_byte};

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	ien_reset_a: assert property (@(posedge CLK_SYS_IN)
		$fell(SYS_RST_IN) |-> !state_reg.cond_code_byte[cpu_regs_pkg::CC_IEN_POS])
		else $error("enable flag not clear after reset");

	gpr_addr_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		1'b1 |=> GPR_ADDR_OUT == {8'h01, $past(state_reg.bank_select[4:0]),
			$past(GPR_OPCODE_IN)})
		else $error("bank register address wrong");

	zero_flag_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		ALU_OP_IN.valid && ALU_OP_IN.touch.zero && ALU_OP_IN.wide && !REG_WR_IN.en
		|=> state_reg.cond_code_byte[2] == ($past(ALU_OP_IN.result) == 16'h0000))
		else $error("zero flag wrong");

	neg_flag_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		ALU_OP_IN.valid && ALU_OP_IN.touch.neg && !ALU_OP_IN.wide && !REG_WR_IN.en
		|=> state_reg.cond_code_byte[3] == $past(ALU_OP_IN.result[7]))
		else $error("negative flag wrong");

	carry_flag_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		ALU_OP_IN.valid && ALU_OP_IN.touch.carry && !REG_WR_IN.en
		|=> state_reg.cond_code_byte[0] == $past(ALU_OP_IN.carry_out))
		else $error("carry flag wrong");

	flag_keep_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		!REG_WR_IN.en && !(ALU_OP_IN.valid && ALU_OP_IN.touch.ovf)
		|=> $stable(state_reg.cond_code_byte[1]))
		else $error("overflow flag changed untouched");

	irq_gate_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		IRQ_REQ_IN && IRQ_LEVEL_IN >= {state_reg.cond_code_byte[5],
			state_reg.cond_code_byte[4]} |=> !IRQ_ACCEPT_OUT)
		else $error("interrupt accepted at too low a level");

	byte_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REG_WR_IN.en && REG_WR_IN.low_only && REG_WR_IN.sel == cpu_regs_pkg::SEL_ACC
		&& !ALU_OP_IN.valid |=> state_reg.acc[15:8] == $past(state_reg.acc[15:8]))
		else $error("byte write touched accumulator high byte");

	store_order_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		STORE_SEL_IN == cpu_regs_pkg::SEL_STACK
		|=> STORE_LO_ADDR_BYTE_OUT == $past(state_reg.stack_top_ptr[15:8]))
		else $error("store byte order wrong");

	ptr_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REG_WR_IN.en && REG_WR_IN.sel == cpu_regs_pkg::SEL_PTR && !REG_WR_IN.low_only
		|=> INSTR_POINTER_OUT == $past(REG_WR_IN.data))
		else $error("instruction pointer write lost");

	ptr_hold_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		!(REG_WR_IN.en && REG_WR_IN.sel == cpu_regs_pkg::SEL_PTR)
		|=> $stable(INSTR_POINTER_OUT))
		else $error("instruction pointer moved without a write");

	acc_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REG_WR_IN.en && REG_WR_IN.sel == cpu_regs_pkg::SEL_ACC && !ALU_OP_IN.valid
		|=> state_reg.acc[7:0] == $past(REG_WR_IN.data[7:0]))
		else $error("accumulator write lost");

	acc_byte_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		ALU_OP_IN.valid && !ALU_OP_IN.wide
		|=> state_reg.acc == {$past(state_reg.acc[15:8]), $past(ALU_OP_IN.result[7:0])})
		else $error("byte result did not land in the low byte");

	acc_wide_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		ALU_OP_IN.valid && ALU_OP_IN.wide
		|=> state_reg.acc == $past(ALU_OP_IN.result))
		else $error("word result did not land in the accumulator");

	tmp_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REG_WR_IN.en && REG_WR_IN.sel == cpu_regs_pkg::SEL_TMP
		|=> state_reg.tmp_acc[7:0] == $past(REG_WR_IN.data[7:0]))
		else $error("temporary accumulator write lost");

	stack_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REG_WR_IN.en && REG_WR_IN.sel == cpu_regs_pkg::SEL_STACK && !REG_WR_IN.low_only
		|=> state_reg.stack_top_ptr == $past(REG_WR_IN.data))
		else $error("stack pointer write lost");

	index_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REG_WR_IN.en && REG_WR_IN.sel == cpu_regs_pkg::SEL_INDEX && !REG_WR_IN.low_only
		|=> state_reg.index_reg == $past(REG_WR_IN.data))
		else $error("index register write lost");

	extra_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REG_WR_IN.en && REG_WR_IN.sel == cpu_regs_pkg::SEL_EXTRA && !REG_WR_IN.low_only
		|=> state_reg.extra_addr_ptr == $past(REG_WR_IN.data))
		else $error("extra pointer write lost");

	proc_write_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REG_WR_IN.en && REG_WR_IN.sel == cpu_regs_pkg::SEL_PROC && !REG_WR_IN.low_only
		&& !ALU_OP_IN.valid && !IEN_SET_IN && !IEN_CLR_IN && !LEVEL_WR_IN
		|=> PROC_WORD_OUT == $past(REG_WR_IN.data))
		else $error("processor word write lost");

	half_flag_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		ALU_OP_IN.valid && ALU_OP_IN.touch.half && !REG_WR_IN.en
		|=> state_reg.cond_code_byte[7] == $past(ALU_OP_IN.half_carry))
		else $error("half flag wrong");

	ovf_flag_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		ALU_OP_IN.valid && ALU_OP_IN.touch.ovf && !REG_WR_IN.en
		|=> state_reg.cond_code_byte[1] == $past(ALU_OP_IN.ovf))
		else $error("overflow flag wrong");

	neg_wide_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		ALU_OP_IN.valid && ALU_OP_IN.touch.neg && ALU_OP_IN.wide && !REG_WR_IN.en
		|=> state_reg.cond_code_byte[3] == $past(ALU_OP_IN.result[15]))
		else $error("negative flag wrong on word result");

	zero_byte_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		ALU_OP_IN.valid && ALU_OP_IN.touch.zero && !ALU_OP_IN.wide && !REG_WR_IN.en
		|=> state_reg.cond_code_byte[2] == ($past(ALU_OP_IN.result[7:0]) == 8'h00))
		else $error("zero flag wrong on byte result");

	ien_set_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		IEN_SET_IN
		|=> state_reg.cond_code_byte[6])
		else $error("enable flag not set");

	ien_clr_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		IEN_CLR_IN && !IEN_SET_IN
		|=> !state_reg.cond_code_byte[6])
		else $error("enable flag not cleared");

	level_wr_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		LEVEL_WR_IN
		|=> {state_reg.cond_code_byte[5], state_reg.cond_code_byte[4]} == $past(LEVEL_IN))
		else $error("current level not loaded");

	irq_take_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		IRQ_REQ_IN && state_reg.cond_code_byte[6] && IRQ_LEVEL_IN <
			{state_reg.cond_code_byte[5], state_reg.cond_code_byte[4]}
		|=> IRQ_ACCEPT_OUT)
		else $error("interrupt of higher level refused");

	irq_masked_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		!state_reg.cond_code_byte[6]
		|=> !IRQ_ACCEPT_OUT)
		else $error("interrupt accepted while disabled");

	store_hi_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		STORE_SEL_IN == cpu_regs_pkg::SEL_ACC
		|=> STORE_HI_ADDR_BYTE_OUT == $past(state_reg.acc[7:0]))
		else $error("store low byte wrong");

	rd_proc_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		RD_SEL_IN == cpu_regs_pkg::SEL_PROC
		|=> RD_DATA_OUT == $past(PROC_WORD_OUT))
		else $error("processor word read back in another layout");

	bank_keep_a: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		!(REG_WR_IN.en && REG_WR_IN.sel == cpu_regs_pkg::SEL_PROC)
		|=> $stable(state_reg.bank_select))
		else $error("bank select moved without a write");

endmodule

// >>> tb/alu_partner_model.sv
// Behavioural ALU that faces the register set and hands it result records.
// Assumes the bench holds operands steady for the one cycle it raises go_in.
`timescale 1ns/1ns
module alu_partner_model (
	// Operation request
	input  wire logic                     go_in,
	input  wire logic                     wide_in,
	input  wire logic [15:0]              a_in,
	input  wire logic [15:0]              b_in,
	input  wire cpu_regs_pkg::flag_mask_s touch_in,
	// Result record
	output cpu_regs_pkg::alu_op_s         op_out
);
	// ----------------------------------------------------------------
	// Adder
	// ----------------------------------------------------------------
	logic [16:0] wsum;
	logic [8:0]  bsum;
	logic [4:0]  nsum;
	always_comb begin
		wsum              = {1'h0, a_in} + {1'h0, b_in};
		bsum              = {1'h0, a_in[7:0]} + {1'h0, b_in[7:0]};
		nsum              = {1'h0, a_in[3:0]} + {1'h0, b_in[3:0]};
		op_out.valid      = go_in;
		op_out.wide       = wide_in;
		// Idle record carries the inverted a_in, not the last result
		op_out.result     = !go_in ? ~a_in : (wide_in ? wsum[15:0] : {8'h00, bsum[7:0]});
		op_out.carry_out  = bsum[8];
		op_out.half_carry = nsum[4];
		op_out.ovf        = (a_in[7] == b_in[7]) && (bsum[7] != a_in[7]);
		op_out.touch      = touch_in;
	end
endmodule

// >>> tb/cpu_register_set_test.sv
// Self-checking bench for the CPU register set.
// Assumes the package flag positions and a one-cycle registered read path.
`timescale 1ns/1ns
module cpu_register_set_test;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                     clk, rst, ien_set, ien_clr, lvl_wr, irq_req, go, accept, wide;
	logic [1:0]               lvl, irq_lvl;
	logic [2:0]               gpr_op;
	logic [7:0]               st_lo, st_hi;
	logic [15:0]              rd_data, gpr_addr, ip, pw, a, b;
	cpu_regs_pkg::reg_wr_s    wr_bus;
	cpu_regs_pkg::alu_op_s    alu_rec;
	cpu_regs_pkg::reg_sel_e   rd_sel, st_sel;
	cpu_regs_pkg::flag_mask_s touch;
	int                       miscompares, samples_checked;
	logic [15:0]              vals [6] = '{16'h1234, 16'hA55A, 16'h8001, 16'hFFFE, 16'h0F0F, 16'h7E81};

	cpu_register_set #(.BANK_COUNT(16)) cpu_register_set_inst (
		.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .REG_WR_IN(wr_bus), .ALU_OP_IN(alu_rec),
		.IEN_SET_IN(ien_set), .IEN_CLR_IN(ien_clr), .LEVEL_WR_IN(lvl_wr), .LEVEL_IN(lvl),
		.RD_SEL_IN(rd_sel), .RD_DATA_OUT(rd_data), .GPR_OPCODE_IN(gpr_op),
		.GPR_ADDR_OUT(gpr_addr), .IRQ_REQ_IN(irq_req), .IRQ_LEVEL_IN(irq_lvl),
		.IRQ_ACCEPT_OUT(accept), .STORE_SEL_IN(st_sel), .STORE_LO_ADDR_BYTE_OUT(st_lo),
		.STORE_HI_ADDR_BYTE_OUT(st_hi), .INSTR_POINTER_OUT(ip), .PROC_WORD_OUT(pw));
	alu_partner_model alu_partner_model_inst (.go_in(go), .wide_in(wide), .a_in(a),
		.b_in(b), .touch_in(touch), .op_out(alu_rec));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input cpu_regs_pkg::reg_sel_e s, input logic lo, input logic [15:0] d);
		@(posedge clk) wr_bus <= '{1'h1, s, lo, d};
		@(posedge clk) wr_bus.en <= 1'h0;
	endtask
	task automatic rd(input cpu_regs_pkg::reg_sel_e s, input logic [15:0] e);
		@(posedge clk) rd_sel <= s;
		@(posedge clk) #1 chk(rd_data, e);
	endtask
	task automatic gpr(input logic [15:0] pword, input logic [2:0] op, input logic [15:0] e);
		wr(cpu_regs_pkg::SEL_PROC, 1'h0, pword);
		@(posedge clk) gpr_op <= op;
		@(posedge clk) #1 chk(gpr_addr, e);
		chk(pw, pword);
	endtask
	task automatic alu(input logic [7:0] x, input logic [7:0] y, input logic [4:0] t,
			input logic [7:0] cc);
		@(posedge clk) begin
			go <= 1'h1;
			a <= {8'h00, x};
			b <= {8'h00, y};
			touch <= t;
		end
		@(posedge clk) go <= 1'h0;
		#1 chk({8'h00, pw[7:0]}, {8'h00, cc});
	endtask
	task automatic ctl(input logic s, input logic c, input logic w, input logic [1:0] l);
		@(posedge clk) {ien_set, ien_clr, lvl_wr, lvl} <= {s, c, w, l};
		@(posedge clk) {ien_set, ien_clr, lvl_wr} <= 3'h0;
	endtask
	task automatic irq(input logic [1:0] l, input logic e);
		@(posedge clk) {irq_req, irq_lvl} <= {1'h1, l};
		@(posedge clk) irq_req <= 1'h0;
		#1 chk({15'h0000, accept}, {15'h0000, e});
	endtask
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		#(50 * 3000);
		miscompares++;
		wrap_up;
	end
	initial begin
		{rst, ien_set, ien_clr, lvl_wr, irq_req, go, lvl, irq_lvl, gpr_op} = 13'h1000;
		{wr_bus, a, b, touch, wide} = '0;
		rd_sel = cpu_regs_pkg::SEL_PTR;
		st_sel = cpu_regs_pkg::SEL_PTR;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		#1 chk(pw, 16'h0030);
		chk(ip, 16'h0000);
		for (int i = 0; i < 6; i++)
			wr(cpu_regs_pkg::reg_sel_e'(i), 1'h0, vals[i]);
		for (int i = 0; i < 6; i++)
			rd(cpu_regs_pkg::reg_sel_e'(i), vals[i]);
		chk(ip, vals[0]);
		wr(cpu_regs_pkg::SEL_ACC, 1'h1, 16'h99CC);
		rd(cpu_regs_pkg::SEL_ACC, 16'hA5CC);
		@(posedge clk) st_sel <= cpu_regs_pkg::SEL_ACC;
		@(posedge clk) #1 chk({st_lo, st_hi}, 16'hA5CC);
		@(posedge clk) st_sel <= cpu_regs_pkg::SEL_STACK;
		@(posedge clk) #1 chk({st_lo, st_hi}, vals[3]);
		gpr(16'h0F30, 3'h7, 16'h017F);
		gpr(16'h1A30, 3'h5, 16'h01D5);
		rd(cpu_regs_pkg::SEL_PROC, 16'h1A30);
		alu(8'h0F, 8'h01, 5'h1F, 8'hB0);
		alu(8'h80, 8'h80, 5'h1F, 8'h37);
		alu(8'h7F, 8'h01, 5'h1F, 8'hBA);
		alu(8'hFF, 8'h01, 5'h1F, 8'hB5);
		alu(8'h01, 8'h01, 5'h01, 8'hB4);
		rd(cpu_regs_pkg::SEL_ACC, 16'hA502);
		@(posedge clk) wide <= 1'h1;
		alu(8'hFF, 8'h01, 5'h1F, 8'hB1);
		rd(cpu_regs_pkg::SEL_ACC, 16'h0100);
		alu(8'h00, 8'h00, 5'h1F, 8'h34);
		@(posedge clk) wide <= 1'h0;
		irq(2'h0, 1'h0);
		ctl(1'h1, 1'h0, 1'h1, 2'h2);
		#1 chk({8'h00, pw[7:0]}, 16'h0064);
		for (int l = 0; l < 4; l++)
			irq(2'(l), l < 2);
		ctl(1'h0, 1'h1, 1'h0, 2'h0);
		irq(2'h0, 1'h0);
		ctl(1'h1, 1'h0, 1'h1, 2'h1);
		irq(2'h0, 1'h1);
		irq(2'h1, 1'h0);
		ctl(1'h0, 1'h0, 1'h1, 2'h0);
		irq(2'h0, 1'h0);
		wrap_up;
	end
endmodule
